// File: sac_approx.sv
// Successive-approximation register, MSB first
`timescale 1ns/1ps
module sac_approx (
  input wire logic clock,
  input wire logic reset,
  input wire logic clear,
  input wire logic trial,
  input wire logic comp_ge,
  output logic [9:0] tap_q
);
  import sac_pkg::*;
  logic [3:0] pos_q;

  always_ff @(posedge clock) begin
    if (reset || clear) begin
      tap_q <= 10'h200;
      pos_q <= 4'h9;
    end else if (trial) begin
      tap_q[pos_q] <= comp_ge;
      if (pos_q != 4'h0) begin
        tap_q[pos_q - 4'h1] <= 1'b1;
        pos_q <= pos_q - 4'h1;
      end
    end
  end

  msb_first_a: assert property (@(posedge clock) disable iff (reset)
    clear |=> tap_q == 10'h200)
    else $error("trial does not start at bit 9");
endmodule

// File: sac_pkg.sv
// Package of register map, field layout and timing constants for the converter
package sac_pkg;
  localparam logic [15:0] RESULT_WIDE_ADDR = 16'hff08;
  localparam logic [15:0] RESULT_UPPER_ADDR = 16'hff09;
  localparam logic [15:0] MODE_ADDR = 16'hff28;
  localparam logic [15:0] CHAN_ADDR = 16'hff29;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [2:0] CHAN_RESET = 3'h0;
  localparam logic [9:0] RESULT_RESET = 10'h000;
  localparam int RESULT_SHIFT = 6;
  localparam int RESULT_BITS = 10;
  // Conversion length in conversion-clock periods for each low-reference band
  localparam int PERIODS_NORMAL = 22;
  localparam int PERIODS_LOW = 40;
  // Successive approximation occupies the last trials before the end tick
  localparam int TRIAL_COUNT = 10;
  localparam logic [3:0] DIV_12 = 4'hc;
  localparam logic [3:0] DIV_8 = 4'h8;
  localparam logic [3:0] DIV_6 = 4'h6;
  localparam logic [3:0] DIV_4 = 4'h4;
  localparam logic [3:0] DIV_3 = 4'h3;
  localparam logic [3:0] DIV_2 = 4'h2;

  typedef struct packed {
    logic run;
    logic unused;
    logic [2:0] speed;
    logic [1:0] low_ref;
    logic comp_power;
  } sac_mode_s;

  typedef enum logic {SAC_IDLE, SAC_CONVERT} sac_state_e;
endpackage

// File: sac_top.sv
// Converter control: mode, channel select, result registers and sequencing
// Behaviour
// - Speed code 000-101 gives divide 12,8,6,4,3,2; 22 or 40 periods.
// - Wide result is read-only, left-justified, low six bits zero.
// - Upper eight bits at higher byte, low two at top of lower.
// - Wide result clears to zero on reset.
// - Byte result holds upper eight bits, updated each end, reset zero.
// - Result reads take a wait cycle; no reads with clock stopped.
// - Channel select register, reset zero, low three bits pick input.
// - Channel select writes take a wait cycle; none with clock stopped.
// - Convert repeatedly while run bit set; power bit drives comparator.
// - Approximate from bit 9 to 0; keep bit when input at least tap.
// - Pulse done interrupt with each result transfer, on the same edge.
`timescale 1ns/1ps
module sac_top (
  input wire logic clock,
  input wire logic reset,
  input wire logic bus_req,
  input wire logic bus_write,
  input wire logic bus_wide,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  output logic [15:0] bus_rdata_q,
  output logic bus_ack_q,
  output logic bus_wait_q,
  input wire logic comp_ge,
  output logic [9:0] tap_q,
  output logic [2:0] channel_q,
  output logic comparator_power_q,
  output logic sample_hold_q,
  output logic conversion_done_irq_q
);
  import sac_pkg::*;

  sac_mode_s mode_q;
  sac_state_e state_q;
  logic [9:0] result_q;
  logic [3:0] div_cnt_q;
  logic [5:0] fad_cnt_q;
  logic [8:0] clk_cnt_q;
  logic run_prev_q;
  logic [15:0] pend_rdata_q;
  logic pend_q;

  function automatic logic [3:0] speed_div(input logic [2:0] code);
    unique case (code)
      3'h0: speed_div = DIV_12;
      3'h1: speed_div = DIV_8;
      3'h2: speed_div = DIV_6;
      3'h3: speed_div = DIV_4;
      3'h4: speed_div = DIV_3;
      3'h5: speed_div = DIV_2;
      default: speed_div = DIV_12;
    endcase
  endfunction

  function automatic logic [5:0] periods(input logic [1:0] lv);
    periods = lv[0] ? 6'(PERIODS_LOW) : 6'(PERIODS_NORMAL);
  endfunction

  function automatic logic [15:0] read_mux(input logic [15:0] a,
    input logic wide);
    logic [15:0] w;
    w = {result_q, 6'h00};
    read_mux = 16'h0000;
    if (a == RESULT_WIDE_ADDR) read_mux = wide ? w : {8'h00, w[7:0]};
    else if (a == RESULT_UPPER_ADDR) read_mux = {8'h00, w[15:8]};
    else if (a == MODE_ADDR) read_mux = {8'h00, mode_q};
    else if (a == CHAN_ADDR) read_mux = {13'h0000, channel_q};
  endfunction

  logic [3:0] div_sel;
  logic [5:0] nf;
  logic fad_tick;
  logic end_now;
  logic start_now;
  logic trial;
  logic is_result;
  logic needs_wait;

  always_comb begin
    div_sel = speed_div(mode_q.speed);
    nf = periods(mode_q.low_ref);
    fad_tick = (state_q == SAC_CONVERT) && (div_cnt_q == div_sel - 4'h1);
    end_now = fad_tick && (fad_cnt_q == nf - 6'h1);
    trial = fad_tick && (fad_cnt_q >= nf - 6'(TRIAL_COUNT + 1)) &&
      (fad_cnt_q <= nf - 6'h2);
    start_now = mode_q.run && (!run_prev_q || end_now);
    is_result = (bus_addr == RESULT_WIDE_ADDR) ||
      (bus_addr == RESULT_UPPER_ADDR);
    needs_wait = (!bus_write && is_result) ||
      (bus_write && (bus_addr == CHAN_ADDR || bus_addr == MODE_ADDR));
  end

  // Register writes; result registers have no write path at all
  always_ff @(posedge clock) begin
    if (reset) begin
      mode_q <= sac_mode_s'(MODE_RESET);
      channel_q <= CHAN_RESET;
    end else if (bus_req && bus_write && !pend_q) begin
      if (bus_addr == MODE_ADDR)
        mode_q <= {bus_wdata[7], 1'b0, bus_wdata[5:0]};
      // Upper channel bits are not stored so they always read zero
      if (bus_addr == CHAN_ADDR) channel_q <= bus_wdata[2:0];
    end
  end

  // Bus answer: one cycle, or two when a wait cycle is inserted
  always_ff @(posedge clock) begin
    if (reset) begin
      bus_ack_q <= 1'b0;
      bus_wait_q <= 1'b0;
      pend_q <= 1'b0;
      pend_rdata_q <= 16'h0000;
      bus_rdata_q <= 16'h0000;
    end else begin
      bus_ack_q <= 1'b0;
      bus_wait_q <= 1'b0;
      pend_q <= 1'b0;
      if (pend_q) begin
        bus_ack_q <= 1'b1;
        bus_rdata_q <= pend_rdata_q;
      end else if (bus_req && needs_wait) begin
        bus_wait_q <= 1'b1;
        pend_q <= 1'b1;
        pend_rdata_q <= bus_write ? 16'h0000 : read_mux(bus_addr, bus_wide);
      end else if (bus_req) begin
        bus_ack_q <= 1'b1;
        bus_rdata_q <= bus_write ? 16'h0000 : read_mux(bus_addr, bus_wide);
      end
    end
  end

  // Sequencer: repeated conversions while the run bit stays set
  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= SAC_IDLE;
      run_prev_q <= 1'b0;
      div_cnt_q <= 4'h0;
      fad_cnt_q <= 6'h00;
      clk_cnt_q <= 9'h000;
      sample_hold_q <= 1'b0;
    end else begin
      run_prev_q <= mode_q.run;
      if (!mode_q.run) begin
        state_q <= SAC_IDLE;
        sample_hold_q <= 1'b0;
      end else if (start_now) begin
        state_q <= SAC_CONVERT;
        div_cnt_q <= 4'h0;
        fad_cnt_q <= 6'h00;
        clk_cnt_q <= 9'h000;
        sample_hold_q <= 1'b1;
      end else if (state_q == SAC_CONVERT) begin
        clk_cnt_q <= clk_cnt_q + 9'h001;
        div_cnt_q <= fad_tick ? 4'h0 : div_cnt_q + 4'h1;
        if (fad_tick) begin
          fad_cnt_q <= fad_cnt_q + 6'h01;
          // Hold phase begins where the bit trials begin
          if (fad_cnt_q == nf - 6'(TRIAL_COUNT + 2)) sample_hold_q <= 1'b0;
        end
      end
    end
  end

  // Results and interrupt move together at the conversion end
  always_ff @(posedge clock) begin
    if (reset) begin
      result_q <= RESULT_RESET;
      conversion_done_irq_q <= 1'b0;
    end else begin
      conversion_done_irq_q <= end_now && mode_q.run;
      if (end_now && mode_q.run) result_q <= tap_q;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) comparator_power_q <= 1'b0;
    else comparator_power_q <= mode_q.comp_power;
  end

  sac_approx sac_approx_inst (
    .clock(clock),
    .reset(reset),
    .clear(start_now),
    .trial(trial && mode_q.run),
    .comp_ge(comp_ge),
    .tap_q(tap_q)
  );

  logic wide_rd_q;
  always_ff @(posedge clock) begin
    if (reset) wide_rd_q <= 1'b0;
    else wide_rd_q <= bus_req && !bus_write && bus_wide && !pend_q &&
      bus_addr == RESULT_WIDE_ADDR;
  end

  low_bits_a: assert property (@(posedge clock) disable iff (reset)
    wide_rd_q |=> bus_ack_q && bus_rdata_q[5:0] == 6'h00)
    else $error("wide result low bits not zero");
  reset_clear_a: assert property (@(posedge clock)
    reset |=> result_q == RESULT_RESET)
    else $error("result not cleared by reset");
  load_irq_a: assert property (@(posedge clock) disable iff (reset)
    (end_now && mode_q.run) |=> conversion_done_irq_q &&
      result_q == $past(tap_q))
    else $error("result load and interrupt not together");
  conv_length_a: assert property (@(posedge clock) disable iff (reset)
    end_now |-> clk_cnt_q == 9'(div_sel * nf - 1))
    else $error("conversion length wrong");
  read_wait_a: assert property (@(posedge clock) disable iff (reset)
    (bus_req && !bus_write && is_result && !pend_q) |=>
      bus_wait_q && !bus_ack_q ##1 bus_ack_q)
    else $error("result read missing wait cycle");
  chan_wait_a: assert property (@(posedge clock) disable iff (reset)
    (bus_req && bus_write && bus_addr == CHAN_ADDR && !pend_q) |=>
      bus_wait_q ##1 bus_ack_q)
    else $error("channel write missing wait cycle");
  chan_store_a: assert property (@(posedge clock) disable iff (reset)
    (bus_req && bus_write && bus_addr == CHAN_ADDR && !pend_q) |=>
      channel_q == $past(bus_wdata[2:0]))
    else $error("channel code not stored");
  stop_idle_a: assert property (@(posedge clock) disable iff (reset)
    !mode_q.run |=> state_q == SAC_IDLE && !conversion_done_irq_q)
    else $error("converter runs with run bit clear");
  ro_result_a: assert property (@(posedge clock) disable iff (reset)
    (bus_req && bus_write && is_result && !end_now) |=> $stable(result_q))
    else $error("result changed by write");

  done_c: cover property (@(posedge clock) conversion_done_irq_q);
  back_to_back_c: cover property (@(posedge clock)
    conversion_done_irq_q ##[1:1000] conversion_done_irq_q);
  wait_read_c: cover property (@(posedge clock) bus_wait_q ##1 bus_ack_q);
endmodule

// File: sar_adc_control_results_test.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module sar_adc_control_results_test;
  import sac_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic bus_req = 1'b0;
  logic bus_write = 1'b0;
  logic bus_wide = 1'b0;
  logic [15:0] bus_addr = 16'h0000;
  logic [7:0] bus_wdata = 8'h00;
  logic comp_ge = 1'b0;
  logic [15:0] bus_rdata_q;
  logic bus_ack_q;
  logic bus_wait_q;
  logic [9:0] tap_q;
  logic [2:0] channel_q;
  logic comparator_power_q;
  logic sample_hold_q;
  logic conversion_done_irq_q;
  int n_fail = 0;
  int total_checks = 0;
  int target = 0;
  int divs [6] = '{12, 8, 6, 4, 3, 2};

  always #50 clock = ~clock;

  sac_top sac_top_inst (.clock(clock), .reset(reset), .bus_req(bus_req),
    .bus_write(bus_write), .bus_wide(bus_wide), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_rdata_q(bus_rdata_q), .bus_ack_q(bus_ack_q),
    .bus_wait_q(bus_wait_q), .comp_ge(comp_ge), .tap_q(tap_q),
    .channel_q(channel_q), .comparator_power_q(comparator_power_q),
    .sample_hold_q(sample_hold_q),
    .conversion_done_irq_q(conversion_done_irq_q));

  // Analog side stand-in: input level is the integer target
  // The selected pin is taken to be in input mode, so its level is valid
  always @(negedge clock) comp_ge <= (target >= int'(tap_q));

  task automatic report_and_stop();
    if (n_fail == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [9:0] approx(input int t);
    logic [9:0] r;
    r = 10'h000;
    for (int b = 9; b >= 0; b--) begin
      if (t >= int'(r | (10'h001 << b))) r = r | (10'h001 << b);
    end
    return r;
  endfunction

  task automatic bus(input logic wr, input logic wide, input logic [15:0] a,
      input logic [7:0] wd, output logic [15:0] rd);
    int i;
    logic got_wait;
    logic exp_wait;
    exp_wait = wr ? (a == MODE_ADDR || a == CHAN_ADDR)
      : (a == RESULT_WIDE_ADDR || a == RESULT_UPPER_ADDR);
    @(negedge clock);
    bus_req = 1'b1;
    bus_write = wr;
    bus_wide = wide;
    bus_addr = a;
    bus_wdata = wd;
    @(negedge clock);
    bus_req = 1'b0;
    got_wait = bus_wait_q;
    i = 0;
    while (bus_ack_q !== 1'b1 && i < 4) begin
      @(negedge clock);
      i++;
    end
    if (i == 4) begin
      n_fail++;
      report_and_stop();
    end
    rd = bus_rdata_q;
    check({15'h0, got_wait}, {15'h0, exp_wait});
    check(16'(i), {15'h0, exp_wait});
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic wide,
      input logic [15:0] exp);
    logic [15:0] rd;
    bus(1'b0, wide, a, 8'h00, rd);
    check(rd, exp);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [15:0] rd;
    bus(1'b1, 1'b0, a, d, rd);
  endtask

  task automatic wait_irq(output int n, output int h);
    n = 0;
    h = 0;
    do begin
      @(negedge clock);
      n++;
      if (sample_hold_q === 1'b1) h++;
    end while (conversion_done_irq_q !== 1'b1 && n < 1200);
    if (n == 1200) begin
      n_fail++;
      report_and_stop();
    end
  endtask

  initial begin
    int n;
    int s;
    int lv;
    int seen;
    int h;
    int p;
    logic [9:0] e;
    logic [7:0] m;
    void'($urandom(32'h2debc8b1));
    repeat (12) @(negedge clock);
    reset = 1'b0;
    rd_chk(RESULT_WIDE_ADDR, 1'b1, 16'h0000);
    rd_chk(RESULT_UPPER_ADDR, 1'b0, 16'h0000);
    rd_chk(CHAN_ADDR, 1'b0, {13'h0000, CHAN_RESET});
    rd_chk(MODE_ADDR, 1'b0, {8'h00, MODE_RESET});
    rd_chk(16'hff30, 1'b0, 16'h0000);
    // Eight-input variant: codes 110 and 111 exist there
    for (int c = 0; c < 8; c++) begin
      wr(CHAN_ADDR, 8'(c));
      check({13'h0000, channel_q}, 16'(c));
      rd_chk(CHAN_ADDR, 1'b0, 16'(c));
    end
    for (int k = 0; k < 12; k++) begin
      s = k % 6;
      lv = k / 6;
      target = int'($urandom % 1024);
      m = {1'b1, 1'b0, 3'(s), 1'b0, 1'(lv), 1'(k % 2)};
      wr(MODE_ADDR, m);
      check({15'h0, comparator_power_q}, {15'h0, m[0]});
      rd_chk(MODE_ADDR, 1'b0, {8'h00, m});
      // First result may predate a settled comparator, so it is skipped
      wait_irq(n, h);
      wait_irq(n, h);
      p = (lv == 1) ? PERIODS_LOW : PERIODS_NORMAL;
      check(16'(n), 16'(divs[s] * p));
      check(16'(h), 16'(divs[s] * (p - TRIAL_COUNT - 1)));
      check({6'h00, tap_q}, 16'h0200);
      e = approx(target);
      rd_chk(RESULT_WIDE_ADDR, 1'b1, {e, 6'h00});
      rd_chk(RESULT_WIDE_ADDR, 1'b0, {8'h00, e[1:0], 6'h00});
      rd_chk(RESULT_UPPER_ADDR, 1'b0, {8'h00, e[9:2]});
      wr(RESULT_UPPER_ADDR, ~e[9:2]);
      rd_chk(RESULT_UPPER_ADDR, 1'b0, {8'h00, e[9:2]});
      wr(MODE_ADDR, 8'h00);
      seen = 0;
      repeat (500) begin
        @(negedge clock);
        if (conversion_done_irq_q === 1'b1) seen = 1;
      end
      check(16'(seen), 16'h0000);
      check({15'h0, sample_hold_q}, 16'h0000);
    end
    target = 700;
    wr(MODE_ADDR, 8'ha1);
    wait_irq(n, h);
    reset = 1'b1;
    repeat (2) @(negedge clock);
    reset = 1'b0;
    rd_chk(RESULT_WIDE_ADDR, 1'b1, 16'h0000);
    rd_chk(RESULT_UPPER_ADDR, 1'b0, 16'h0000);
    rd_chk(CHAN_ADDR, 1'b0, 16'h0000);
    report_and_stop();
  end
endmodule
